// ---- design/jdrs_pkg.sv ----
// Function
// (RULE1) Valve held open for refill time
// (RULE2) Valve held closed for dwell time after
// (RULE3) Times in 0.1 ms steps
// (RULE4) Drop period equals refill plus dwell
// (RULE5) Six independent stored recipes
// (RULE6) Extra time adds to refill time
// (RULE7) Dot mode: extra added every drop
// (RULE8) Bead mode: extra only first drop
// (RULE9) Idle timer enables long-idle extra
// (RULE10) Long-idle extra only on first drop
// (RULE11) Each trigger input starts own recipe
// (RULE12) Busy line high idle, low dispensing
// (RULE13) Controller should pace triggers by busy
// (RULE14) Edge trigger gives programmed drop count
// (RULE15) Each accepted trigger gives drop set
// (RULE16) Trigger during cycle is ignored
// (RULE17) Level trigger repeats while asserted
// (RULE18) First drop: long extra past timeout
// (RULE19) Idle timer restarts at dispense end
package jdrs_pkg;
    localparam int NUM_RECIPES = 6;
    localparam int TIME_W      = 16;
    localparam int CNT_W       = 16;
    localparam int SEC_W       = 8;
    // ----------------------------------------
    // Register map (byte addresses, word per recipe field)
    // ----------------------------------------
    localparam logic [7:0] REG_REFILL  = 8'h00;
    localparam logic [7:0] REG_DWELL   = 8'h04;
    localparam logic [7:0] REG_EXTRA1  = 8'h08;
    localparam logic [7:0] REG_EXTRA2  = 8'h0C;
    localparam logic [7:0] REG_IDLESEC = 8'h10;
    localparam logic [7:0] REG_DROPS   = 8'h14;
    localparam logic [7:0] REG_FORMAT  = 8'h18;
    localparam logic [7:0] REG_STATUS  = 8'h80;
    localparam logic [7:0] REG_IRQ_ST  = 8'h84;
    localparam logic [7:0] REG_IRQ_MSK = 8'h88;
    localparam logic [7:0] RECIPE_STRIDE = 8'h20;
    localparam int FMT_LEVEL_BIT = 0;
    localparam int FMT_BEAD_BIT  = 1;
    localparam int IRQ_START_BIT = 0;
    localparam int IRQ_DONE_BIT  = 1;
    localparam int IRQ_DROP_BIT  = 2;
    localparam int IRQ_W         = 3;
    localparam logic [CNT_W-1:0] DROPS_RESET = 16'h0001;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ       = 50_000_000;
    localparam int TICK_US      = 100;
    localparam int TICK_CYCLES  = CLK_HZ / 1_000_000 * TICK_US;
    localparam int TICKS_PER_S  = 1_000_000 / TICK_US;
    typedef struct packed {
        logic [TIME_W-1:0] refill;
        logic [TIME_W-1:0] dwell;
        logic [TIME_W-1:0] extra1;
        logic [TIME_W-1:0] extra2;
        logic [SEC_W-1:0]  idle_sec;
        logic [CNT_W-1:0]  drops;
        logic              level;
        logic              bead;
    } jdrs_recipe_t;
endpackage

// ---- design/jdrs_top.sv ----
`timescale 1ns/100ps
module jdrs_top #(
    parameter int TICK_CYCLES = jdrs_pkg::TICK_CYCLES
) (
    input  wire logic                                mclk,
    input  wire logic                                nrst,
    input  wire logic [7:0]                          avs_address,
    input  wire logic                                avs_read,
    input  wire logic                                avs_write,
    input  wire logic [31:0]                         avs_writedata,
    output logic      [31:0]                         avs_readdata,
    output logic                                     avs_waitrequest,
    input  wire logic [jdrs_pkg::NUM_RECIPES-1:0]    trig_in,
    output logic                                     valve_open,
    output logic                                     jet_active_indicator,
    output logic                                     irq
);
    localparam int NR = jdrs_pkg::NUM_RECIPES;
    localparam int TW = jdrs_pkg::TIME_W;
    localparam int CW = jdrs_pkg::CNT_W;

    // ----------------------------------------
    // Trigger synchroniser
    // ----------------------------------------
    logic [NR-1:0] trig_s1_r;
    logic [NR-1:0] trig_s2_r;
    logic [NR-1:0] trig_prev_r;
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            trig_s1_r   <= '0;
            trig_s2_r   <= '0;
            trig_prev_r <= '0;
        end
        else
        begin
            trig_s1_r   <= trig_in;
            trig_s2_r   <= trig_s1_r;
            trig_prev_r <= trig_s2_r;
        end
    end
    wire [NR-1:0] trig_rise = trig_s2_r & ~trig_prev_r;

    // ----------------------------------------
    // 0.1 ms tick and one second tick
    // ----------------------------------------
    logic [15:0] pre_r;
    logic [15:0] sec_div_r;
    wire         tick = (pre_r == 16'(TICK_CYCLES - 1));
    wire         sec_tick = tick && (sec_div_r == 16'(jdrs_pkg::TICKS_PER_S - 1));
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pre_r     <= 16'h0000;
            sec_div_r <= 16'h0000;
        end
        else
        begin
            pre_r <= tick ? 16'h0000 : pre_r + 16'h0001; // see (RULE3)
            if (tick)
                sec_div_r <= sec_tick ? 16'h0000 : sec_div_r + 16'h0001;
        end
    end

    // ----------------------------------------
    // Recipe store
    // ----------------------------------------
    jdrs_pkg::jdrs_recipe_t rcp_r [NR]; // see (RULE5)
    wire [2:0] wr_idx  = avs_address[7:5];
    wire [7:0] wr_fld  = {3'b000, avs_address[4:0]};
    wire       wr_rcp  = avs_write && !avs_waitrequest && (wr_idx < 3'(NR));
    genvar gi;
    generate
        for (gi = 0; gi < NR; gi++)
        begin : g_rcp
            always_ff @(posedge mclk or negedge nrst)
            begin
                if (!nrst)
                begin
                    rcp_r[gi]       <= '0;
                    rcp_r[gi].drops <= jdrs_pkg::DROPS_RESET;
                end
                else if (wr_rcp && wr_idx == 3'(gi))
                begin
                    case (wr_fld)
                        jdrs_pkg::REG_REFILL:  rcp_r[gi].refill   <= avs_writedata[TW-1:0];
                        jdrs_pkg::REG_DWELL:   rcp_r[gi].dwell    <= avs_writedata[TW-1:0];
                        jdrs_pkg::REG_EXTRA1:  rcp_r[gi].extra1   <= avs_writedata[TW-1:0];
                        jdrs_pkg::REG_EXTRA2:  rcp_r[gi].extra2   <= avs_writedata[TW-1:0];
                        jdrs_pkg::REG_IDLESEC:
                            rcp_r[gi].idle_sec <= avs_writedata[jdrs_pkg::SEC_W-1:0];
                        jdrs_pkg::REG_DROPS:   rcp_r[gi].drops    <= avs_writedata[CW-1:0];
                        jdrs_pkg::REG_FORMAT:
                        begin
                            rcp_r[gi].level <= avs_writedata[jdrs_pkg::FMT_LEVEL_BIT];
                            rcp_r[gi].bead  <= avs_writedata[jdrs_pkg::FMT_BEAD_BIT];
                        end
                        default: ;
                    endcase
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_OPEN, ST_CLOSED} jdrs_state_t;
    jdrs_state_t state_r;
    logic [2:0]   sel_r;
    logic [TW:0]  tcnt_r;
    logic [CW-1:0] left_r;
    logic         first_r;
    logic         long_r;
    logic [jdrs_pkg::SEC_W-1:0] idle_s_r;

    // Lowest numbered rising trigger wins when two arrive together
    function automatic logic [2:0] pick(input logic [NR-1:0] v);
        logic [2:0] p;
        p = 3'd0;
        for (int k = NR - 1; k >= 0; k--)
            if (v[k])
                p = 3'(k);
        return p;
    endfunction

    wire                   start    = (state_r == ST_IDLE) && (|trig_rise); // see (RULE16)
    wire [2:0]             new_sel  = pick(trig_rise); // see (RULE11)
    jdrs_pkg::jdrs_recipe_t cur;
    assign cur = rcp_r[start ? new_sel : sel_r];
    wire                   long_now = (idle_s_r >= cur.idle_sec); // see (RULE9)
    wire                   use_long = start ? long_now : long_r;
    wire                   is_first = start || first_r;
    // see (RULE18) see (RULE10)
    wire [TW:0] extra = !is_first ? (cur.bead ? '0 : {1'b0, cur.extra1})  // see (RULE7) (RULE8)
                       : (use_long ? {1'b0, cur.extra2} : {1'b0, cur.extra1});
    wire [TW:0] open_len = {1'b0, cur.refill} + extra; // see (RULE6)
    wire        phase_end = tick && (tcnt_r <= 17'h0_0001);
    wire        trig_held = trig_s2_r[sel_r];
    // Level format ignores the count; edge format counts down
    wire        more = cur.level ? trig_held : (left_r > 16'h0001); // see (RULE14) (RULE17)
    wire        drop_done = (state_r == ST_CLOSED) && phase_end;
    wire        seq_done  = drop_done && !more;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= ST_IDLE;
            sel_r   <= 3'd0;
            tcnt_r  <= '0;
            left_r  <= '0;
            first_r <= 1'b0;
            long_r  <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                    if (start) // see (RULE15)
                    begin
                        sel_r   <= new_sel;
                        long_r  <= long_now;
                        first_r <= 1'b0;
                        left_r  <= cur.drops;
                        tcnt_r  <= open_len;
                        state_r <= ST_OPEN;
                    end
                ST_OPEN:
                    if (phase_end) // see (RULE1)
                    begin
                        tcnt_r  <= {1'b0, cur.dwell};
                        state_r <= ST_CLOSED;
                    end
                    else if (tick)
                        tcnt_r <= tcnt_r - 17'h0_0001;
                ST_CLOSED:
                    if (phase_end) // see (RULE2) (RULE4)
                    begin
                        if (more)
                        begin
                            left_r  <= left_r - 16'h0001;
                            tcnt_r  <= open_len;
                            state_r <= ST_OPEN;
                        end
                        else
                            state_r <= ST_IDLE;
                    end
                    else if (tick)
                        tcnt_r <= tcnt_r - 17'h0_0001;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Idle seconds counter, saturating
    // ----------------------------------------
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            idle_s_r <= '1;
        else if (state_r != ST_IDLE)
            idle_s_r <= '0; // see (RULE19)
        else if (sec_tick && idle_s_r != '1)
            idle_s_r <= idle_s_r + 8'h01;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    wire open_nxt = (state_r == ST_IDLE) ? start
                  : (state_r == ST_OPEN) ? !phase_end
                  : (phase_end && more);
    wire busy_nxt = (state_r == ST_IDLE) ? start : !seq_done;
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            valve_open           <= 1'b0;
            jet_active_indicator <= 1'b1;
        end
        else
        begin
            valve_open           <= open_nxt;
            jet_active_indicator <= !busy_nxt; // see (RULE12)
        end
    end

    // ----------------------------------------
    // Interrupts and Avalon slave
    // ----------------------------------------
    logic [jdrs_pkg::IRQ_W-1:0] ist_r;
    logic [jdrs_pkg::IRQ_W-1:0] imsk_r;
    logic                       wait_r;
    wire [jdrs_pkg::IRQ_W-1:0] ev = {drop_done, seq_done, start};
    wire acc   = (avs_read || avs_write) && !avs_waitrequest;
    wire rd_st = acc && avs_read && avs_address == jdrs_pkg::REG_IRQ_ST;
    jdrs_pkg::jdrs_recipe_t rrc;
    assign rrc = rcp_r[(wr_idx < 3'(NR)) ? wr_idx : 3'd0];
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (avs_address == jdrs_pkg::REG_STATUS)
            rd_mux = {28'h000_0000, sel_r, state_r != ST_IDLE};
        else if (avs_address == jdrs_pkg::REG_IRQ_ST)
            rd_mux = {29'h0000_0000, ist_r};
        else if (avs_address == jdrs_pkg::REG_IRQ_MSK)
            rd_mux = {29'h0000_0000, imsk_r};
        else if (wr_idx < 3'(NR))
            case (wr_fld)
                jdrs_pkg::REG_REFILL:  rd_mux = {16'h0000, rrc.refill};
                jdrs_pkg::REG_DWELL:   rd_mux = {16'h0000, rrc.dwell};
                jdrs_pkg::REG_EXTRA1:  rd_mux = {16'h0000, rrc.extra1};
                jdrs_pkg::REG_EXTRA2:  rd_mux = {16'h0000, rrc.extra2};
                jdrs_pkg::REG_IDLESEC: rd_mux = {24'h00_0000, rrc.idle_sec};
                jdrs_pkg::REG_DROPS:   rd_mux = {16'h0000, rrc.drops};
                jdrs_pkg::REG_FORMAT:  rd_mux = {30'h0000_0000, rrc.bead, rrc.level};
                default:               rd_mux = 32'h0000_0000;
            endcase
    end
    // One wait cycle per access so read data come from a flop
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            wait_r       <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            ist_r        <= '0;
            imsk_r       <= '0;
            irq          <= 1'b0;
        end
        else
        begin
            wait_r <= !((avs_read || avs_write) && wait_r);
            if ((avs_read || avs_write) && wait_r)
                avs_readdata <= rd_mux;
            // New events win over the clearing read
            ist_r <= (rd_st ? '0 : ist_r) | ev;
            if (acc && avs_write && avs_address == jdrs_pkg::REG_IRQ_MSK)
                imsk_r <= avs_writedata[jdrs_pkg::IRQ_W-1:0];
            irq <= |(ist_r & imsk_r);
        end
    end
    assign avs_waitrequest = wait_r;
endmodule

// ---- dv/jdrs_bench.sv ----
`timescale 1ns/100ps
module jdrs_bench;
    localparam int TK = 4;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [5:0]  trig_in;
    logic        valve_open;
    logic        jet_active_indicator;
    logic        irq;
    logic [31:0] rd;
    int          fail_count = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          on_n = 0;
    int          off_n = 0;
    int          opens[$];
    int          closes[$];

    jdrs_top #(.TICK_CYCLES(TK)) uut (.mclk(mclk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trig_in(trig_in),
        .valve_open(valve_open), .jet_active_indicator(jet_active_indicator), .irq(irq));
    jdrs_robot robot (.mclk(mclk), .jet_active_indicator(jet_active_indicator),
        .trig_in(trig_in));

    initial forever #10 mclk = ~mclk;

    // ----------------------------------------
    // Phase monitor, sampled off the active edge
    // ----------------------------------------
    always @(negedge mclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            fail_count++;
            end_of_test();
        end
        if (valve_open === 1'b1)
            on_n++;
        else if (on_n > 0)
        begin
            opens.push_back(on_n);
            on_n = 0;
        end
        if (valve_open === 1'b0 && jet_active_indicator === 1'b0)
            off_n++;
        else if (off_n > 0)
        begin
            closes.push_back(off_n);
            off_n = 0;
        end
    end

    task automatic end_of_test;
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        // Seen low off the edge, then taken at the edge where it is sampled low
        do @(negedge mclk); while (avs_waitrequest !== 1'b0);
        @(posedge mclk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic setr(input logic [7:0] b, input logic [31:0] r, w, e1, e2, s, n, f);
        bus(1'b1, b, r);
        bus(1'b1, b + 8'h04, w);
        bus(1'b1, b + 8'h08, e1);
        bus(1'b1, b + 8'h0C, e2);
        bus(1'b1, b + 8'h10, s);
        bus(1'b1, b + 8'h14, n);
        bus(1'b1, b + 8'h18, f);
    endtask

    task automatic wait_idle;
        while (jet_active_indicator !== 1'b0) @(negedge mclk);
        while (jet_active_indicator !== 1'b1) @(negedge mclk);
        repeat (2) @(posedge mclk);
    endtask

    task automatic run(input int k, input int hold);
        opens.delete();
        closes.delete();
        robot.fire(k, hold, 1'b1);
        wait_idle();
    endtask

    task automatic ck(input int i, input int n);
        check(opens[i] > (n - 1) * TK && opens[i] <= n * TK, "open time");
    endtask

    task automatic t_regs;
        bus(1'b0, 8'hB4, 32'h0000_0000);
        check(rd === 32'h0000_0001, "drops reset");
        bus(1'b0, 8'h88, 32'h0000_0000);
        check(rd === 32'h0000_0000, "mask reset");
        bus(1'b1, 8'hE0, 32'h0000_0005);
        bus(1'b0, 8'hE0, 32'h0000_0000);
        check(rd === 32'h0000_0000, "unmapped read");
        setr(8'h00, 3, 2, 1, 4, 5, 2, 0);
        bus(1'b0, 8'h08, 32'h0000_0000);
        check(rd === 32'h0000_0001, "readback");
    endtask

    task automatic t_dot;
        run(0, 8);
        check(opens.size() == 2, "drop count");
        ck(0, 7);
        ck(1, 4);
        check(closes.size() == 2 && closes[0] == 2 * TK && closes[1] == 2 * TK, "dwell");
        check(irq === 1'b0, "masked irq");
        run(0, 8);
        ck(0, 4);
        ck(1, 4);
    endtask

    task automatic t_ignore;
        bus(1'b1, 8'h88, 32'h0000_0007);
        bus(1'b0, 8'h84, 32'h0000_0000);
        opens.delete();
        robot.fire(0, 8, 1'b1);
        robot.fire(1, 8, 1'b0);
        wait_idle();
        check(opens.size() == 2 && irq === 1'b1, "busy trigger");
        bus(1'b0, 8'h84, 32'h0000_0000);
        check(rd[2:0] === 3'b111, "irq status");
        repeat (3) @(posedge mclk);
        check(irq === 1'b0, "irq cleared");
        bus(1'b0, 8'h84, 32'h0000_0000);
        check(rd[2:0] === 3'b000, "status cleared");
    endtask

    task automatic t_bead;
        setr(8'h20, 5, 2, 1, 4, 200, 3, 2);
        run(1, 8);
        check(opens.size() == 3, "bead count");
        ck(0, 6);
        ck(1, 5);
        ck(2, 5);
    endtask

    task automatic t_level;
        setr(8'h40, 2, 2, 0, 0, 200, 1, 1);
        run(2, 60);
        check(opens.size() >= 3, "level repeats");
    endtask

    initial
    begin
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        t_regs();
        t_dot();
        t_ignore();
        t_bead();
        t_level();
        end_of_test();
    end
endmodule

// ---- dv/jdrs_properties.sv ----
`timescale 1ns/100ps
module jdrs_checker (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [5:0]  trig_in,
    input wire logic        valve_open,
    input wire logic        jet_active_indicator,
    input wire logic        irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=>
        !avs_waitrequest) else $error("bus answer late");
    a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_data_hold: assert property (!avs_read && !avs_write && avs_waitrequest |=>
        $stable(avs_readdata)) else $error("read data moved");
    a_valve_busy: assert property (valve_open |-> !jet_active_indicator)
        else $error("valve open while idle");
    a_start_open: assert property ($fell(jet_active_indicator) |-> $rose(valve_open))
        else $error("start without open phase");
    a_end_closed: assert property ($rose(jet_active_indicator) |->
        !valve_open && !$past(valve_open)) else $error("end without closed phase");
    a_trig_start: assert property (jet_active_indicator && $rose(|trig_in) |->
        ##[2:6] !jet_active_indicator) else $error("trigger not taken");
    a_irq_clear: assert property (avs_read && !avs_waitrequest && avs_address == 8'h84
        && jet_active_indicator && trig_in == 6'h00 |-> ##3 !irq)
        else $error("irq stays after clear");
endmodule
bind jdrs_top jdrs_checker chk (.mclk(mclk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .trig_in(trig_in), .valve_open(valve_open),
    .jet_active_indicator(jet_active_indicator), .irq(irq));

// ---- dv/jdrs_robot.sv ----
`timescale 1ns/100ps
module jdrs_robot (
    input  wire logic       mclk,
    input  wire logic       jet_active_indicator,
    output logic      [5:0] trig_in
);
    initial trig_in = 6'h00;
    // Unpaced fire is how the bench provokes an ignored trigger
    task automatic fire(input int k, input int hold, input bit pace);
        if (pace)
            while (jet_active_indicator !== 1'b1) @(posedge mclk);
        @(posedge mclk);
        trig_in[k] <= 1'b1;
        repeat (hold) @(posedge mclk);
        trig_in[k] <= 1'b0;
    endtask
endmodule
